/* port_pin_map.vh */
// Constants for the port pin override and sleep clamp block.
// Assumes an Avalon-MM master with byte addresses and 32-bit data.
// How it works
// - Sleep clamps each pin's digital input to zero ahead of the schmitt trigger.
// - Pins with external interrupt enabled escape the sleep clamp; otherwise clamped.
// - Clamp edge on a high interrupt pin sets its flag by wake, except in level sense.
// - Pull-ups are forced off while reset is active.
// - Inputs stay enabled in reset, active and idle; clamp only in deep sleep.
// - Without override, pull-up on only when dir, latch, kill equal 0b010.
// - With pull-up override enabled, override value alone decides the pull-up.
// - Driver enable comes from direction bit, or override value when overridden.
// - Drive override enabled: driver follows override value, ignoring direction bit.
// - Driven value comes from value override when enabled, else output latch.
// - Value override enabled: port value equals override value, ignoring latch.
// - Input enable from override value when enabled, else from sleep state.
// - Input enable override wins over both normal and sleep modes.
// - Schmitt output goes to peripherals; they synchronise it themselves.
// - Strobes shared per port, clock/sleep/kill shared, overrides per pin.
// - Direction high drives latch value; low is input with latch-selected pull-up.
// - Global pull-up kill at control bit 6 turns off every pull-up not under override.
// - Sample path uses a falling-edge register followed by a rising-edge register.
// - Pins go high impedance as soon as reset asserts, without clock.
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

`define PIN_COUNT 8
`define ADDR_W 5

`define OFS_LATCH 5'h00
`define OFS_DIR 5'h04
`define OFS_SAMPLE 5'h08
`define OFS_MCU_CTRL 5'h0C
`define OFS_IRQ_CTRL 5'h10
`define OFS_IRQ_FLAG 5'h14

`define BIT_PULLUP_KILL 6
`define BIT_SENSE_LO 0
`define BIT_SENSE_HI 1
`define BIT_IRQ_EN 0
`define BIT_IRQ_FLAG 0
`define IRQ_PIN 0

`define SENSE_LEVEL 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000

`endif

/* pin_cell.v */
// Combinational logic of one port pin: pull-up, driver, value, input gate.
// Assumes override inputs come from the peripheral owning the pin.
`timescale 1ns/100ps
module pin_cell (
  input wire dir_bit_i,        // Direction bit
  input wire latch_bit_i,      // Output latch bit
  input wire pullup_kill_i,    // Global pull-up kill
  input wire sleep_i,          // Deep sleep clamp request
  input wire clamp_bypass_i,   // External interrupt enabled on this pin
  input wire pu_ovr_en_i,      // Pull-up override enable
  input wire pu_ovr_val_i,     // Pull-up override value
  input wire drv_ovr_en_i,     // Drive override enable
  input wire drv_ovr_val_i,    // Drive override value
  input wire val_ovr_en_i,     // Value override enable
  input wire val_ovr_val_i,    // Value override value
  input wire in_ovr_en_i,      // Input enable override enable
  input wire in_ovr_val_i,     // Input enable override value
  input wire pad_in_i,         // Pad level
  output wire pullup_o,        // Pull-up enable
  output wire drive_en_o,      // Output driver enable
  output wire drive_val_o,     // Driven value
  output wire schmitt_o        // Gated schmitt output
);
  wire input_en;

  assign pullup_o = pu_ovr_en_i ? pu_ovr_val_i :
                    (~dir_bit_i & latch_bit_i & ~pullup_kill_i);
  assign drive_en_o = drv_ovr_en_i ? drv_ovr_val_i : dir_bit_i;
  assign drive_val_o = val_ovr_en_i ? val_ovr_val_i : latch_bit_i;
  // Clamp only in deep sleep, never for an armed interrupt pin
  assign input_en = in_ovr_en_i ? in_ovr_val_i :
                    ~(sleep_i & ~clamp_bypass_i);
  assign schmitt_o = input_en & pad_in_i;
endmodule // pin_cell

/* port_pin_override_and_sleep_clamp.v */
// Top of one 8-pin port: Avalon-MM registers, per-pin override cells,
// sample synchroniser and the external interrupt edge flag on pin 0.
// Assumes overrides and sleep come synchronous to core_clk_i.
`timescale 1ns/100ps
`include "port_pin_map.vh"
module port_pin_override_and_sleep_clamp (
  input wire core_clk_i,                  // I/O clock
  input wire rst_n_i,                     // Async reset, active low
  input wire [4:0] avs_address_i,         // Byte address
  input wire avs_read_i,                  // Read request
  input wire avs_write_i,                 // Write request
  input wire [3:0] avs_byteenable_i,      // Byte lanes
  input wire [31:0] avs_writedata_i,      // Write data
  output wire [31:0] avs_readdata_o,      // Read data
  output wire avs_waitrequest_o,          // Wait request
  input wire sleep_i,                     // Deep sleep from sleep controller
  input wire [7:0] pullup_override_en_i,  // Per-pin pull-up override enable
  input wire [7:0] pullup_override_val_i, // Per-pin pull-up override value
  input wire [7:0] drive_ovr_en_i,        // Per-pin drive override enable
  input wire [7:0] drive_ovr_val_i,       // Per-pin drive override value
  input wire [7:0] value_override_en_i,   // Per-pin value override enable
  input wire [7:0] value_override_val_i,  // Per-pin value override value
  input wire [7:0] input_enable_override_en_i,  // Per-pin input enable override
  input wire [7:0] input_enable_override_val_i, // Per-pin input enable value
  input wire [7:0] pad_in_i,              // Pad levels
  output wire [7:0] pad_out_o,            // Pad drive value
  output wire [7:0] pad_oe_o,             // Pad drive enable, high drives
  output wire [7:0] pullup_en_o,          // Pad pull-up enable
  output wire [7:0] alt_fn_schmitt_out_o, // Schmitt output to peripherals
  output wire ext_irq_o                   // External interrupt request
);
  reg [7:0] latch_reg;
  reg [7:0] dir_reg;
  reg [7:0] sample_reg;
  reg [7:0] mcu_ctrl_reg;
  reg irq_en_reg;
  reg irq_flag_reg;
  reg irq_flag_next;
  reg prev_irq_pin_reg;
  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [7:0] pad_out_reg;
  reg [7:0] pad_oe_reg;
  reg [7:0] pullup_reg;
  reg [7:0] schmitt_reg;
  reg irq_out_reg;
  reg [7:0] sync_latch_reg;

  wire [7:0] pullup_c;
  wire [7:0] drive_en_c;
  wire [7:0] drive_val_c;
  wire [7:0] schmitt_c;
  wire [7:0] clamp_bypass;
  wire pullup_kill;
  wire [1:0] sense;
  wire req;
  wire take;
  wire wr_ok;
  wire cur_pin;
  wire edge_hit;

  assign pullup_kill = mcu_ctrl_reg[`BIT_PULLUP_KILL];
  assign sense = {mcu_ctrl_reg[`BIT_SENSE_HI], mcu_ctrl_reg[`BIT_SENSE_LO]};
  assign clamp_bypass = {7'h00, irq_en_reg};

  // One instance per pin; only the strobes and globals are shared
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_pin
      pin_cell u_cell (
        .dir_bit_i(dir_reg[g]),
        .latch_bit_i(latch_reg[g]),
        .pullup_kill_i(pullup_kill),
        .sleep_i(sleep_i),
        .clamp_bypass_i(clamp_bypass[g]),
        .pu_ovr_en_i(pullup_override_en_i[g]),
        .pu_ovr_val_i(pullup_override_val_i[g]),
        .drv_ovr_en_i(drive_ovr_en_i[g]),
        .drv_ovr_val_i(drive_ovr_val_i[g]),
        .val_ovr_en_i(value_override_en_i[g]),
        .val_ovr_val_i(value_override_val_i[g]),
        .in_ovr_en_i(input_enable_override_en_i[g]),
        .in_ovr_val_i(input_enable_override_val_i[g]),
        .pad_in_i(pad_in_i[g]),
        .pullup_o(pullup_c[g]),
        .drive_en_o(drive_en_c[g]),
        .drive_val_o(drive_val_c[g]),
        .schmitt_o(schmitt_c[g])
      );
    end
  endgenerate

  // First stage holds what the clock-high latch kept when the clock fell;
  // taken on the falling edge so no latch is inferred. Only sample_reg reads it
  always @(negedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_latch_reg <= `RST_BYTE;
    end else begin
      sync_latch_reg <= schmitt_c;
    end
  end

  // Pad-side flops; async reset tri-states and drops pull-ups with no clock
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_out_reg <= `RST_BYTE;
      pad_oe_reg <= `RST_BYTE;
      pullup_reg <= `RST_BYTE;
      schmitt_reg <= `RST_BYTE;
      sample_reg <= `RST_BYTE;
      prev_irq_pin_reg <= 1'b0;
      irq_out_reg <= 1'b0;
    end else begin
      pad_out_reg <= drive_val_c;
      pad_oe_reg <= drive_en_c;
      pullup_reg <= pullup_c;
      schmitt_reg <= schmitt_c;
      sample_reg <= sync_latch_reg;
      prev_irq_pin_reg <= sample_reg[`IRQ_PIN];
      irq_out_reg <= irq_flag_next & irq_en_reg;
    end
  end

  // Edge sensing runs even with the interrupt disabled, so the clamp edge counts
  assign cur_pin = sample_reg[`IRQ_PIN];
  assign edge_hit = ((sense == `SENSE_ANY) && (cur_pin != prev_irq_pin_reg)) ||
                    ((sense == `SENSE_FALL) && !cur_pin && prev_irq_pin_reg) ||
                    ((sense == `SENSE_RISE) && cur_pin && !prev_irq_pin_reg);

  // One wait cycle per access; read data lands as wait drops, the write on the edge ending the wait-low cycle
  assign req = avs_read_i | avs_write_i;
  assign take = req & ~wait_reg;
  assign wr_ok = take & avs_write_i & avs_byteenable_i[0];

  always @* begin
    rdata_next = `RST_WORD;
    case (avs_address_i)
      `OFS_LATCH: rdata_next[7:0] = latch_reg;
      `OFS_DIR: rdata_next[7:0] = dir_reg;
      `OFS_SAMPLE: rdata_next[7:0] = sample_reg;
      `OFS_MCU_CTRL: rdata_next[7:0] = mcu_ctrl_reg;
      `OFS_IRQ_CTRL: rdata_next[`BIT_IRQ_EN] = irq_en_reg;
      `OFS_IRQ_FLAG: rdata_next[`BIT_IRQ_FLAG] = irq_flag_reg;
      default: rdata_next = `RST_WORD;
    endcase
  end

  // Set beats a same-cycle write-one clear
  always @* begin
    irq_flag_next = irq_flag_reg;
    if (wr_ok && (avs_address_i == `OFS_IRQ_FLAG) && avs_writedata_i[`BIT_IRQ_FLAG]) begin
      irq_flag_next = 1'b0;
    end
    if (edge_hit) begin
      irq_flag_next = 1'b1;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= `RST_WORD;
      latch_reg <= `RST_BYTE;
      dir_reg <= `RST_BYTE;
      mcu_ctrl_reg <= `RST_BYTE;
      irq_en_reg <= 1'b0;
      irq_flag_reg <= 1'b0;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (req & wait_reg) begin
        rdata_reg <= rdata_next;
      end
      irq_flag_reg <= irq_flag_next;
      if (wr_ok) begin
        case (avs_address_i)
          `OFS_LATCH: latch_reg <= avs_writedata_i[7:0];
          `OFS_DIR: dir_reg <= avs_writedata_i[7:0];
          `OFS_MCU_CTRL: begin
            mcu_ctrl_reg[`BIT_PULLUP_KILL] <= avs_writedata_i[`BIT_PULLUP_KILL];
            mcu_ctrl_reg[`BIT_SENSE_HI] <= avs_writedata_i[`BIT_SENSE_HI];
            mcu_ctrl_reg[`BIT_SENSE_LO] <= avs_writedata_i[`BIT_SENSE_LO];
          end
          `OFS_IRQ_CTRL: irq_en_reg <= avs_writedata_i[`BIT_IRQ_EN];
          default: irq_en_reg <= irq_en_reg;
        endcase
      end
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign pad_out_o = pad_out_reg;
  assign pad_oe_o = pad_oe_reg;
  assign pullup_en_o = pullup_reg;
  assign alt_fn_schmitt_out_o = schmitt_reg;
  assign ext_irq_o = irq_out_reg;
endmodule // port_pin_override_and_sleep_clamp

/* port_pin_asserts.sv */
// Checker for the port pin block, bound to its top module.
// Assumes pad outputs are registered and lag their causes by one edge.
`timescale 1ns/100ps
module port_pin_asserts (
  input wire core_clk_i, // Clock
  input wire rst_n_i, // Reset
  input wire avs_read_i, // Read
  input wire avs_write_i, // Write
  input wire avs_waitrequest_o, // Wait
  input wire sleep_i, // Sleep
  input wire [7:0] pullup_override_en_i, // Pull-up ovr
  input wire [7:0] pullup_override_val_i, // Pull-up val
  input wire [7:0] drive_ovr_en_i, // Drive ovr
  input wire [7:0] drive_ovr_val_i, // Drive val
  input wire [7:0] value_override_en_i, // Value ovr
  input wire [7:0] value_override_val_i, // Value val
  input wire [7:0] input_enable_override_en_i, // Input ovr
  input wire [7:0] input_enable_override_val_i, // Input val
  input wire [7:0] pad_in_i, // Pads in
  input wire [7:0] pad_out_o, // Pads out
  input wire [7:0] pad_oe_o, // Pads enable
  input wire [7:0] pullup_en_o, // Pull-ups
  input wire [7:0] alt_fn_schmitt_out_o // Schmitt tap
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Low until the first edge: before it the reset branch has not yet run
  logic armed = 1'b0;
  always @(posedge core_clk_i) armed <= 1'b1;
  // Past-reset guard: outputs still hold reset values on the first edge
  AST_PULLUP_OVR: assert property ($past(rst_n_i) |-> ((pullup_en_o ^ $past(pullup_override_val_i))
    & $past(pullup_override_en_i)) == 8'h00) else $error("pull-up ignores override");
  AST_DRIVE_OVR: assert property ($past(rst_n_i) |-> ((pad_oe_o ^ $past(drive_ovr_val_i))
    & $past(drive_ovr_en_i)) == 8'h00) else $error("driver ignores override");
  AST_VALUE_OVR: assert property ($past(rst_n_i) |-> ((pad_out_o ^ $past(value_override_val_i))
    & $past(value_override_en_i)) == 8'h00) else $error("value ignores override");
  AST_INPUT_OFF: assert property ($past(rst_n_i) |-> (alt_fn_schmitt_out_o &
    $past(input_enable_override_en_i) & ~$past(input_enable_override_val_i)) == 8'h00)
    else $error("disabled input not zero");
  AST_INPUT_ON: assert property ($past(rst_n_i) |-> ((alt_fn_schmitt_out_o ^ $past(pad_in_i))
    & $past(input_enable_override_en_i) & $past(input_enable_override_val_i)) == 8'h00)
    else $error("forced input not passed");
  AST_SLEEP_CLAMP: assert property ($past(rst_n_i) && $past(sleep_i) |-> (alt_fn_schmitt_out_o
    & ~$past(input_enable_override_en_i) & 8'hFE) == 8'h00) else $error("sleep clamp missing");
  AST_AWAKE: assert property ($past(rst_n_i) && !$past(sleep_i) |-> ((alt_fn_schmitt_out_o
    ^ $past(pad_in_i)) & ~$past(input_enable_override_en_i)) == 8'h00) else $error("input clamped");
  AST_RESET_SAFE: assert property (disable iff (1'h0) armed && !rst_n_i |->
    pad_oe_o == 8'h00 && pullup_en_o == 8'h00) else $error("pads active in reset");
  AST_WAIT_ONE: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("wait low too long");
  AST_WAIT_ANS: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("no answer after one wait");
  COV_SLEEP: cover property (sleep_i ##1 !sleep_i);
  COV_DRIVE: cover property (drive_ovr_en_i != 8'h00 ##1 pad_oe_o != 8'h00);
  COV_READ: cover property (avs_read_i && !avs_waitrequest_o);
endmodule // port_pin_asserts

bind port_pin_override_and_sleep_clamp port_pin_asserts port_pin_asserts_inst (.*);

/* periph_ovr_model.sv */
// Peripheral stand-in that owns and drives the per-pin override signals.
// Assumes the bench hands it the wanted pattern as eight 8-bit groups.
`timescale 1ns/100ps
module periph_ovr_model (
  input wire core_clk_i, // Clock
  input wire slow_i, // One extra cycle of latency
  input wire [63:0] req_i, // Wanted overrides
  output logic [63:0] ovr_o // Registered overrides
);
  logic [63:0] stage_reg;
  // Made from the peripheral's own flops, separately for each pin
  always @(posedge core_clk_i) begin
    stage_reg <= req_i;
    ovr_o <= slow_i ? stage_reg : req_i;
  end
endmodule // periph_ovr_model

/* tb.sv */
// Self-checking bench for the port pin override and sleep clamp block.
// Assumes one wait state per access and one edge of lag on pad outputs.
`timescale 1ns/100ps
module tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic rd = 1'h0, wr = 1'h0, slow = 1'h0, sleep = 1'h0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [7:0] pad = 8'h00;
  logic [63:0] req = 64'h0;
  logic [31:0] q;
  wire [63:0] ovr;
  wire [31:0] rdata;
  wire wait_r, irq;
  wire [7:0] p_out, p_oe, p_pu, p_sch;
  int miscompares = 0, n_checks = 0, cycles = 0;
  logic [7:0] dirs [4] = '{8'h0F, 8'h0F, 8'h0F, 8'hC3};
  logic [63:0] ovs [4] = '{64'h0, 64'h0, 64'h0000A5F0183C0FAA, 64'h00000FFFE7FFF055};
  always #2 clk = ~clk;
  periph_ovr_model periph_ovr_model_inst (.core_clk_i(clk), .slow_i(slow), .req_i(req),
    .ovr_o(ovr));
  port_pin_override_and_sleep_clamp port_pin_override_and_sleep_clamp_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r), .sleep_i(sleep),
    .pullup_override_en_i(ovr[7:0]), .pullup_override_val_i(ovr[15:8]),
    .drive_ovr_en_i(ovr[23:16]), .drive_ovr_val_i(ovr[31:24]),
    .value_override_en_i(ovr[39:32]), .value_override_val_i(ovr[47:40]),
    .input_enable_override_en_i(ovr[55:48]), .input_enable_override_val_i(ovr[63:56]),
    .pad_in_i(pad), .pad_out_o(p_out), .pad_oe_o(p_oe), .pullup_en_o(p_pu),
    .alt_fn_schmitt_out_o(p_sch), .ext_irq_o(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    @(posedge clk);
    while (wait_r !== 1'h0) @(posedge clk);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(nm, {24'h000000, e}, q);
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Expected {pull-up, driver enable, driven value} from latch, direction and overrides
  function automatic logic [23:0] pins(input logic [7:0] dr, lt, input logic k,
    input logic [63:0] o);
    return {(o[7:0] & o[15:8]) | (~o[7:0] & ~dr & lt & {8{~k}}),
      (o[23:16] & o[31:24]) | (~o[23:16] & dr), (o[39:32] & o[47:40]) | (~o[39:32] & lt)};
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h1, 5'h00, 8'hFF);
    bus(1'h1, 5'h04, 8'h01);
    settle();
    chk("pads", {8'h00, pins(8'h01, 8'hFF, 1'h0, 64'h0)}, {8'h00, p_pu, p_oe, p_out});
    @(posedge clk);
    rst_n <= 1'h0;
    #1 chk("reset pads", 32'h00000000, {8'h00, p_pu, p_oe, p_out});
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rchk("latch", 5'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 5'h04, dirs[i]);
      bus(1'h1, 5'h00, 8'h33);
      bus(1'h1, 5'h0C, (i % 2) ? 8'h40 : 8'h00);
      req <= ovs[i];
      slow <= (i == 3);
      settle();
      chk("pads", {8'h00, pins(dirs[i], 8'h33, i % 2, ovs[i])}, {8'h00, p_pu, p_oe, p_out});
    end
    rchk("dir", 5'h04, 8'hC3);
    rchk("ctrl", 5'h0C, 8'h40);
    req <= 64'h0;
    pad <= 8'hFF;
    sleep <= 1'h1;
    settle();
    chk("clamp", 32'h00000000, {24'h000000, p_sch});
    bus(1'h1, 5'h10, 8'h01);
    settle();
    chk("irq pin", 32'h00000001, {24'h000000, p_sch});
    rchk("irq en", 5'h10, 8'h01);
    req <= 64'h80C0000000000000;
    settle();
    chk("forced in", 32'h00000081, {24'h000000, p_sch});
    @(posedge clk);
    sleep <= 1'h0;
    settle();
    chk("awake", 32'h000000BF, {24'h000000, p_sch});
    @(posedge clk);
    req <= 64'h0;
    settle();
    rchk("sample", 5'h08, 8'hFF);
    rchk("unmapped", 5'h18, 8'h00);
    bus(1'h1, 5'h10, 8'h00);
    for (int s = 0; s < 4; s++) begin
      bus(1'h1, 5'h0C, s[7:0]);
      bus(1'h1, 5'h14, 8'h01);
      rchk("flag clear", 5'h14, 8'h00);
      sleep <= 1'h1;
      settle();
      @(posedge clk);
      sleep <= 1'h0;
      settle();
      rchk("wake flag", 5'h14, (s != 0) ? 8'h01 : 8'h00);
      chk("irq", 32'h00000000, {31'h00000000, irq});
    end
    bus(1'h1, 5'h10, 8'h01);
    settle();
    chk("irq on", 32'h00000001, {31'h00000000, irq});
    bus(1'h1, 5'h14, 8'h01);
    settle();
    chk("irq off", 32'h00000000, {31'h00000000, irq});
    complete_run();
  end
endmodule // tb
